// [common/spi_pin_map.svh]
`ifndef SPI_PIN_MAP_SVH
`define SPI_PIN_MAP_SVH
`define SPI_SCK_PIN_STD 3'h6
`define SPI_SCK_PIN_REMAP 3'h7
`define SPI_MISO_PIN_STD 3'h5
`define SPI_MISO_PIN_REMAP 3'h6
`define SPI_MOSI_PIN_STD 3'h7
`define SPI_MOSI_PIN_REMAP 3'h5
`define SPI_SS_PIN_STD 3'h1
`define SPI_SS_PIN_REMAP 3'h4
`define SPI_BITS_PER_BYTE 4'h8
`define SPI_LAST_HALF 4'hF
`define SPI_RATE_TIMER1 3'h7
`define SPI_MASTER_RST 1'b0
`define SPI_BYTE_RST 8'h00
`endif

// [common/spi_pin_pkg.sv]
package spi_pin_pkg;
    // drive mode of a port pin
    typedef enum logic [1:0] {
        PM_QUASI = 2'h0,
        PM_PUSH = 2'h1,
        PM_INPUT = 2'h2,
        PM_OPEN = 2'h3
    } port_mode_t;

    // one-hot engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_MASTER = 3'h2,
        ST_SLAVE = 3'h4
    } state_t;

    // software control bits
    typedef struct packed {
        logic spi_enable_bit;
        logic select_disable_bit;
        logic cpha;
        logic bit_order_control;
        logic remap;
        logic [2:0] rate_select_field;
        logic irq_enable;
    } spi_cfg_t;

    // status seen by software
    typedef struct packed {
        logic master_select_bit;
        logic busy;
        logic transfer_complete_flag;
        logic mode_fault_flag;
        logic select_error_flag;
    } spi_status_t;
endpackage

// [rtl/spi_rate_gen.sv]
`timescale 1ns/1ps
`include "spi_pin_map.svh"
module spi_rate_gen (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic run_i,
    input wire logic [2:0] rate_sel_i,
    input wire logic t1_ovf_i,
    output logic tick_o
);
    logic [6:0] pre_r;
    logic [6:0] pre_nxt;
    logic [6:0] mask;

    // prescaler restarts at each transfer so the first half bit is whole
    always_comb
    begin
        pre_nxt = run_i ? pre_r + 7'h01 : 7'h00;
        mask = 7'(~(7'h7F << rate_sel_i));
        if (rate_sel_i == `SPI_RATE_TIMER1)
            tick_o = run_i & t1_ovf_i;
        else
            tick_o = run_i & ((pre_r & mask) == mask);
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            pre_r <= 7'h00;
        else
            pre_r <= pre_nxt;
    end
endmodule

// [rtl/spi_pin_and_select_control.sv]
`timescale 1ns/1ps
`include "spi_pin_map.svh"
module spi_pin_and_select_control (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire spi_pin_pkg::spi_cfg_t cfg_i,
    input wire logic master_set_i,
    input wire logic master_clr_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    input wire logic transfer_complete_flag_clr_i,
    input wire logic mode_fault_flag_clr_i,
    input wire logic isp_active_i,
    input wire logic ss_gpio_i,
    input wire logic t1_ovf_i,
    input wire logic [15:0] port_mode_i,
    input wire logic [7:0] p1_in_i,
    output logic [7:0] p1_out_o,
    output logic [7:0] p1_oe_n_o,
    output logic [7:0] rx_data_o,
    output spi_pin_pkg::spi_status_t status_o,
    output logic irq_o
);
    // mode of one port 1 pin
    function automatic spi_pin_pkg::port_mode_t mode_of(input logic [15:0] pm, input logic [2:0] idx);
        mode_of = spi_pin_pkg::port_mode_t'(pm[{idx, 1'b0} +: 2]);
    endfunction

    // pin drive as {out, oe_n}
    function automatic logic [1:0] pin_drive(input spi_pin_pkg::port_mode_t m, input logic v, input logic en);
        if (!en || m == spi_pin_pkg::PM_INPUT)
            pin_drive = 2'h3;
        else if (m == spi_pin_pkg::PM_OPEN)
            pin_drive = {v, v};
        else
            pin_drive = {v, 1'b0};
    endfunction

    // bit leaving the shifter
    function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
        out_bit = lsb ? sh[0] : sh[7];
    endfunction

    // shift one bit in, direction by bit order
    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic lsb);
        shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction

    spi_pin_pkg::state_t state_r, state_nxt;
    logic master_r, master_nxt;
    logic [7:0] tx_sh_r, tx_sh_nxt;
    logic [7:0] rx_sh_r, rx_sh_nxt;
    logic [7:0] tx_buf_r, tx_buf_nxt;
    logic tx_full_r, tx_full_nxt;
    logic [7:0] rx_buf_r, rx_buf_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic [3:0] half_r, half_nxt;
    logic sck_r, sck_nxt;
    logic sck_prev_r;
    logic ss_prev_r;
    logic transfer_complete_flag_r, transfer_complete_flag_nxt;
    logic mode_fault_flag_r, mode_fault_flag_nxt;
    logic select_error_flag_r, select_error_flag_nxt;
    logic [7:0] pin_out_r, pin_out_nxt;
    logic [7:0] pin_oe_n_r, pin_oe_n_nxt;
    logic [2:0] sck_idx, miso_idx, mosi_idx, ss_idx;
    logic remap_eff, ss_in, sck_in, data_in;
    logic fault, slave_sel, tick, lead, trail, sample, shift, done;
    logic [1:0] drv;

    // master bit clock source
    spi_rate_gen u_rate (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .run_i(state_r == spi_pin_pkg::ST_MASTER),
        .rate_sel_i(cfg_i.rate_select_field),
        .t1_ovf_i(t1_ovf_i),
        .tick_o(tick)
    );

    // pin placement and role decode
    always_comb
    begin
        remap_eff = cfg_i.remap | isp_active_i;
        sck_idx = remap_eff ? `SPI_SCK_PIN_REMAP : `SPI_SCK_PIN_STD;
        miso_idx = remap_eff ? `SPI_MISO_PIN_REMAP : `SPI_MISO_PIN_STD;
        mosi_idx = remap_eff ? `SPI_MOSI_PIN_REMAP : `SPI_MOSI_PIN_STD;
        ss_idx = remap_eff ? `SPI_SS_PIN_REMAP : `SPI_SS_PIN_STD;
        ss_in = p1_in_i[ss_idx];
        sck_in = p1_in_i[sck_idx];
        data_in = master_r ? p1_in_i[miso_idx] : p1_in_i[mosi_idx];
        fault = cfg_i.spi_enable_bit & master_r & !cfg_i.select_disable_bit & !ss_in;
        slave_sel = !master_r & ((cfg_i.cpha & cfg_i.select_disable_bit) | !ss_in);
        // master edges from the rate tick, slave edges from the pin at any rate
        if (state_r == spi_pin_pkg::ST_MASTER)
        begin
            lead = tick & !sck_r;
            trail = tick & sck_r;
        end
        else
        begin
            lead = (state_r == spi_pin_pkg::ST_SLAVE) & slave_sel & sck_in & !sck_prev_r;
            trail = (state_r == spi_pin_pkg::ST_SLAVE) & slave_sel & !sck_in & sck_prev_r;
        end
        sample = cfg_i.cpha ? trail : lead;
        shift = cfg_i.cpha ? (lead & (bit_cnt_r != 4'h0)) : trail;
        if (state_r == spi_pin_pkg::ST_MASTER)
            done = trail & (half_r == `SPI_LAST_HALF);
        else
            done = sample & (bit_cnt_r == `SPI_BITS_PER_BYTE - 4'h1);
    end

    // engine, flags and pin next values
    always_comb
    begin
        state_nxt = state_r;
        master_nxt = master_r;
        tx_sh_nxt = tx_sh_r;
        rx_sh_nxt = rx_sh_r;
        tx_buf_nxt = tx_buf_r;
        tx_full_nxt = tx_full_r;
        rx_buf_nxt = rx_buf_r;
        bit_cnt_nxt = bit_cnt_r;
        half_nxt = half_r;
        sck_nxt = sck_r;
        transfer_complete_flag_nxt = transfer_complete_flag_r & !transfer_complete_flag_clr_i;
        mode_fault_flag_nxt = mode_fault_flag_r & !mode_fault_flag_clr_i;
        select_error_flag_nxt = select_error_flag_r & cfg_i.spi_enable_bit;
        pin_out_nxt = 8'hFF;
        pin_oe_n_nxt = 8'hFF;
        drv = 2'h3;
        if (tx_valid_i && !tx_full_r)
        begin
            tx_buf_nxt = tx_data_i;
            tx_full_nxt = 1'b1;
        end
        if (master_set_i)
            master_nxt = 1'b1;
        else if (master_clr_i)
            master_nxt = 1'b0;
        if (sample)
        begin
            rx_sh_nxt = shift_in(rx_sh_r, data_in, cfg_i.bit_order_control);
            bit_cnt_nxt = bit_cnt_r + 4'h1;
        end
        if (shift)
            tx_sh_nxt = shift_in(tx_sh_r, 1'b1, cfg_i.bit_order_control);
        if (lead || trail)
        begin
            half_nxt = half_r + 4'h1;
            sck_nxt = (state_r == spi_pin_pkg::ST_MASTER) ? !sck_r : sck_r;
        end
        if (done)
        begin
            transfer_complete_flag_nxt = 1'b1;
            rx_buf_nxt = rx_sh_nxt;
            bit_cnt_nxt = 4'h0;
            half_nxt = 4'h0;
        end
        case (state_r)
            spi_pin_pkg::ST_IDLE:
            begin
                if (cfg_i.spi_enable_bit && !master_r)
                    state_nxt = spi_pin_pkg::ST_SLAVE;
                else if (cfg_i.spi_enable_bit && tx_full_r && !fault)
                begin
                    state_nxt = spi_pin_pkg::ST_MASTER;
                    tx_sh_nxt = tx_buf_r;
                    tx_full_nxt = 1'b0;
                    sck_nxt = 1'b0;
                end
            end
            spi_pin_pkg::ST_MASTER:
            begin
                if (done)
                    state_nxt = spi_pin_pkg::ST_IDLE;
            end
            spi_pin_pkg::ST_SLAVE:
            begin
                if (master_r)
                    state_nxt = spi_pin_pkg::ST_IDLE;
                else if (!slave_sel)
                begin
                    // select released mid-byte drops the partial byte
                    if (ss_in && !ss_prev_r && bit_cnt_r != 4'h0)
                        select_error_flag_nxt = 1'b1;
                    bit_cnt_nxt = 4'h0;
                end
                else if (bit_cnt_r == 4'h0 && tx_full_r && !lead && !trail)
                begin
                    tx_sh_nxt = tx_buf_r;
                    tx_full_nxt = 1'b0;
                end
            end
            default:
                state_nxt = spi_pin_pkg::ST_IDLE;
        endcase
        if (fault)
        begin
            master_nxt = 1'b0;
            mode_fault_flag_nxt = 1'b1;
            state_nxt = spi_pin_pkg::ST_IDLE;
            bit_cnt_nxt = 4'h0;
            half_nxt = 4'h0;
            sck_nxt = 1'b0;
        end
        if (!cfg_i.spi_enable_bit)
        begin
            state_nxt = spi_pin_pkg::ST_IDLE;
            bit_cnt_nxt = 4'h0;
            half_nxt = 4'h0;
            sck_nxt = 1'b0;
        end
        // pin direction follows the role while enabled
        else if (master_r)
        begin
            drv = pin_drive(mode_of(port_mode_i, sck_idx), sck_nxt, !fault);
            pin_out_nxt[sck_idx] = drv[1];
            pin_oe_n_nxt[sck_idx] = drv[0];
            drv = pin_drive(mode_of(port_mode_i, mosi_idx), out_bit(tx_sh_nxt, cfg_i.bit_order_control),
                            state_nxt == spi_pin_pkg::ST_MASTER);
            pin_out_nxt[mosi_idx] = drv[1];
            pin_oe_n_nxt[mosi_idx] = drv[0];
            if (cfg_i.select_disable_bit)
            begin
                drv = pin_drive(mode_of(port_mode_i, ss_idx), ss_gpio_i, 1'b1);
                pin_out_nxt[ss_idx] = drv[1];
                pin_oe_n_nxt[ss_idx] = drv[0];
            end
        end
        else
        begin
            drv = pin_drive(mode_of(port_mode_i, miso_idx), out_bit(tx_sh_nxt, cfg_i.bit_order_control),
                            slave_sel);
            pin_out_nxt[miso_idx] = drv[1];
            pin_oe_n_nxt[miso_idx] = drv[0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            state_r <= spi_pin_pkg::ST_IDLE;
            master_r <= `SPI_MASTER_RST;
            tx_sh_r <= `SPI_BYTE_RST;
            rx_sh_r <= `SPI_BYTE_RST;
            tx_buf_r <= `SPI_BYTE_RST;
            tx_full_r <= 1'b0;
            rx_buf_r <= `SPI_BYTE_RST;
            bit_cnt_r <= 4'h0;
            half_r <= 4'h0;
            sck_r <= 1'b0;
            sck_prev_r <= 1'b0;
            ss_prev_r <= 1'b1;
            transfer_complete_flag_r <= 1'b0;
            mode_fault_flag_r <= 1'b0;
            select_error_flag_r <= 1'b0;
            pin_out_r <= 8'hFF;
            pin_oe_n_r <= 8'hFF;
        end
        else
        begin
            state_r <= state_nxt;
            master_r <= master_nxt;
            tx_sh_r <= tx_sh_nxt;
            rx_sh_r <= rx_sh_nxt;
            tx_buf_r <= tx_buf_nxt;
            tx_full_r <= tx_full_nxt;
            rx_buf_r <= rx_buf_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            half_r <= half_nxt;
            sck_r <= sck_nxt;
            sck_prev_r <= sck_in;
            ss_prev_r <= ss_in;
            transfer_complete_flag_r <= transfer_complete_flag_nxt;
            mode_fault_flag_r <= mode_fault_flag_nxt;
            select_error_flag_r <= select_error_flag_nxt;
            pin_out_r <= pin_out_nxt;
            pin_oe_n_r <= pin_oe_n_nxt;
        end
    end

    // outputs; select error never reaches the interrupt
    assign tx_ready_o = !tx_full_r;
    assign p1_out_o = pin_out_r;
    assign p1_oe_n_o = pin_oe_n_r;
    assign rx_data_o = rx_buf_r;
    assign status_o = '{master_r, state_r != spi_pin_pkg::ST_IDLE && bit_cnt_r != 4'h0 || state_r == spi_pin_pkg::ST_MASTER,
                        transfer_complete_flag_r, mode_fault_flag_r, select_error_flag_r};
    assign irq_o = cfg_i.irq_enable & (transfer_complete_flag_r | mode_fault_flag_r);

    // rising edges of the master clock within one byte
    logic [3:0] rise_cnt_r;
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i || state_r != spi_pin_pkg::ST_MASTER)
            rise_cnt_r <= 4'h0;
        else if (tick && !sck_r)
            rise_cnt_r <= rise_cnt_r + 4'h1;
    end

    demote_master_a: assert property (@(posedge clk_i) disable iff (!resetn_i) fault |=> !master_r)
        else $error("master kept after select fault");
    fault_flag_a: assert property (@(posedge clk_i) disable iff (!resetn_i) fault |=> mode_fault_flag_r && irq_o == cfg_i.irq_enable)
        else $error("mode fault not flagged");
    stay_slave_a: assert property (@(posedge clk_i) disable iff (!resetn_i) !master_r && !master_set_i |=> !master_r)
        else $error("master restored without software");
    mode_fault_flag_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i) mode_fault_flag_r && !mode_fault_flag_clr_i |=> mode_fault_flag_r)
        else $error("mode fault lost");
    eight_clocks_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        state_r == spi_pin_pkg::ST_MASTER && done |-> rise_cnt_r == `SPI_BITS_PER_BYTE)
        else $error("master byte not eight clocks");
    done_flag_a: assert property (@(posedge clk_i) disable iff (!resetn_i) done && !fault |=> transfer_complete_flag_r && rx_buf_r == $past(rx_sh_nxt))
        else $error("transfer end not flagged");
    miso_release_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !master_r && ss_in && !(cfg_i.cpha && cfg_i.select_disable_bit) |-> pin_oe_n_nxt[miso_idx])
        else $error("slave drives miso while deselected");
    mosi_idle_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        master_r && state_nxt != spi_pin_pkg::ST_MASTER |-> pin_oe_n_nxt[mosi_idx])
        else $error("mosi driven outside transfer");
    input_only_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        mode_of(port_mode_i, sck_idx) == spi_pin_pkg::PM_INPUT |-> pin_oe_n_nxt[sck_idx])
        else $error("input-only clock pin driven");
    select_error_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        state_r == spi_pin_pkg::ST_SLAVE && !master_r && !slave_sel && ss_in && !ss_prev_r && bit_cnt_r != 4'h0
        && cfg_i.spi_enable_bit |=> select_error_flag_r)
        else $error("select error missed");
endmodule

// [tb/spi_far_model.sv]
`timescale 1ns/1ps
`include "spi_pin_map.svh"
module spi_far_model (
    input wire logic clk_i,
    input wire logic remap_i,
    input wire logic lsb_first_i,
    input wire logic [7:0] dev_out_i,
    input wire logic [7:0] dev_oe_n_i,
    output logic [7:0] pin_o
);
    logic [2:0] sck_p, miso_p, mosi_p, ss_p;
    logic [7:0] drv, val, got, seen;
    logic [7:0] reply = 8'h00;
    logic [7:0] rises = 8'h00;
    logic [3:0] falls = 4'h0;
    logic slave_on = 1'b0;
    logic mst_on = 1'b0;
    logic sck_v = 1'b0;
    logic mosi_v = 1'b1;
    logic ss_drv = 1'b0;
    logic ss_v = 1'b1;
    logic sck_q = 1'b0;
    logic miso_v;
    logic sck_dev, fall_now;
    logic [2:0] bit_idx;
    int cyc = 0;
    int last = 0;
    int per = 0;

    // pin positions follow the remap choice
    assign sck_p = remap_i ? `SPI_SCK_PIN_REMAP : `SPI_SCK_PIN_STD;
    assign miso_p = remap_i ? `SPI_MISO_PIN_REMAP : `SPI_MISO_PIN_STD;
    assign mosi_p = remap_i ? `SPI_MOSI_PIN_REMAP : `SPI_MOSI_PIN_STD;
    assign ss_p = remap_i ? `SPI_SS_PIN_REMAP : `SPI_SS_PIN_STD;
    // a device clock fall moves the reply bit in the same cycle, as a real slave would
    assign sck_dev = dev_oe_n_i[sck_p] | dev_out_i[sck_p];
    assign fall_now = sck_q & !sck_dev;
    assign bit_idx = falls[2:0] + {2'h0, fall_now};
    assign miso_v = lsb_first_i ? reply[bit_idx] : reply[3'h7 - bit_idx];

    // far side drive; a released line rests at the pull-up level
    always_comb
    begin
        drv = 8'h00;
        val = 8'hFF;
        drv[miso_p] = slave_on;
        val[miso_p] = miso_v;
        drv[sck_p] = mst_on;
        val[sck_p] = sck_v;
        drv[mosi_p] = mst_on;
        val[mosi_p] = mosi_v;
        drv[ss_p] = ss_drv;
        val[ss_p] = ss_v;
        for (int k = 0; k < 8; k++)
            pin_o[k] = !dev_oe_n_i[k] ? dev_out_i[k] : (drv[k] ? val[k] : 1'b1);
    end

    function automatic logic [7:0] sh(input logic [7:0] r, input logic b);
        return lsb_first_i ? {b, r[7:1]} : {r[6:0], b};
    endfunction

    // watches the device clock: counts edges, period, captures mosi
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        sck_q <= pin_o[sck_p];
        if (pin_o[sck_p] && !sck_q)
        begin
            rises <= rises + 8'h01;
            per <= cyc - last;
            last <= cyc;
            got <= sh(got, pin_o[mosi_p]);
        end
        if (!pin_o[sck_p] && sck_q)
            falls <= falls + 4'h1;
    end

    task automatic clr();
        rises = 8'h00;
        falls = 4'h0;
    endtask

    // one frame as external master, n bits, own slow rate
    task automatic frame(input logic [7:0] b, input logic cp, input logic use_ss, input int n);
        logic [2:0] k;
        mst_on = 1'b1;
        sck_v = 1'b0;
        ss_drv = use_ss;
        ss_v = 1'b0;
        repeat (4) @(negedge clk_i);
        for (int i = 0; i < n; i++)
        begin
            k = lsb_first_i ? i[2:0] : 3'h7 - i[2:0];
            if (!cp)
                mosi_v = b[k];
            repeat (4) @(negedge clk_i);
            sck_v = 1'b1;
            if (cp)
                mosi_v = b[k];
            else
                seen = sh(seen, pin_o[miso_p]);
            repeat (4) @(negedge clk_i);
            sck_v = 1'b0;
            if (cp)
                seen = sh(seen, pin_o[miso_p]);
        end
        repeat (4) @(negedge clk_i);
        ss_drv = 1'b0;
    endtask
endmodule

// [tb/spi_pin_and_select_control_tb.sv]
`timescale 1ns/1ps
module spi_pin_and_select_control_tb;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    spi_pin_pkg::spi_cfg_t cfg = '0;
    spi_pin_pkg::spi_status_t status_o;
    logic master_set_i = 1'b0, master_clr_i = 1'b0, tx_valid_i = 1'b0, transfer_complete_flag_clr_i = 1'b0;
    logic mode_fault_flag_clr_i = 1'b0, isp_active_i = 1'b0, ss_gpio_i = 1'b1, t1_ovf_i = 1'b0;
    logic [7:0] tx_data_i = 8'h00;
    logic [15:0] port_mode_i = 16'h5555;
    logic [7:0] p1_in_i, p1_out_o, p1_oe_n_o, rx_data_o;
    logic tx_ready_o, irq_o;
    logic [2:0] t1_cnt = 3'h0;
    int n_mismatch = 0;
    int compares = 0;

    always #4 clk_i = ~clk_i;

    // timer 1 overflow every fifth cycle
    always @(negedge clk_i)
    begin
        t1_cnt <= (t1_cnt == 3'h4) ? 3'h0 : t1_cnt + 3'h1;
        t1_ovf_i <= (t1_cnt == 3'h4);
    end

    spi_pin_and_select_control u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .cfg_i(cfg),
        .master_set_i(master_set_i), .master_clr_i(master_clr_i), .tx_valid_i(tx_valid_i),
        .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o), .transfer_complete_flag_clr_i(transfer_complete_flag_clr_i), .mode_fault_flag_clr_i(mode_fault_flag_clr_i),
        .isp_active_i(isp_active_i), .ss_gpio_i(ss_gpio_i), .t1_ovf_i(t1_ovf_i), .port_mode_i(port_mode_i),
        .p1_in_i(p1_in_i), .p1_out_o(p1_out_o), .p1_oe_n_o(p1_oe_n_o), .rx_data_o(rx_data_o),
        .status_o(status_o), .irq_o(irq_o));

    spi_far_model u_far (.clk_i(clk_i), .remap_i(cfg.remap | isp_active_i),
        .lsb_first_i(cfg.bit_order_control), .dev_out_i(p1_out_o), .dev_oe_n_i(p1_oe_n_o), .pin_o(p1_in_i));

    task automatic wrap_up();
        if (n_mismatch == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk1(input logic seen, input logic exp);
        check({7'h0, seen}, {7'h0, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // offer one byte once the transmit buffer is free
    task automatic send(input logic [7:0] b);
        for (int n = 0; n < 500 && tx_ready_o !== 1'b1; n++)
            tick(1);
        tx_valid_i = 1'b1;
        tx_data_i = b;
        tick(1);
        tx_valid_i = 1'b0;
    endtask

    task automatic wait_transfer_complete_flag();
        int n;
        for (n = 0; n < 2000 && status_o.transfer_complete_flag !== 1'b1; n++)
            tick(1);
        chk1(status_o.transfer_complete_flag, 1'b1);
    endtask

    task automatic clr_transfer_complete_flag();
        transfer_complete_flag_clr_i = 1'b1;
        tick(1);
        transfer_complete_flag_clr_i = 1'b0;
        tick(1);
    endtask

    // master exchange against the model as slave
    task automatic mxfer(input logic [7:0] tx, input logic [7:0] rep, input logic [2:0] rate, input int per);
        cfg.rate_select_field = rate;
        u_far.reply = rep;
        u_far.slave_on = 1'b1;
        u_far.clr();
        send(tx);
        for (int n = 0; n < 500 && u_far.rises < 8'h02; n++)
            tick(1);
        chk1(p1_oe_n_o[u_far.sck_p], 1'b0);
        chk1(p1_oe_n_o[u_far.mosi_p], 1'b0);
        chk1(p1_oe_n_o[u_far.miso_p], 1'b1);
        wait_transfer_complete_flag();
        check(rx_data_o, rep);
        check(u_far.got, tx);
        check(u_far.rises, 8'h08);
        check(8'(u_far.per), 8'(per));
        chk1(irq_o, 1'b1);
        tick(3);
        chk1(p1_oe_n_o[u_far.mosi_p], 1'b1);
        clr_transfer_complete_flag();
        u_far.slave_on = 1'b0;
    endtask

    task automatic sframe(input logic [7:0] pre, input logic [7:0] b, input logic cp, input logic use_ss);
        send(pre);
        tick(4);
        u_far.frame(b, cp, use_ss, 8);
        wait_transfer_complete_flag();
        check(rx_data_o, b);
        check(u_far.seen, pre);
        clr_transfer_complete_flag();
    endtask

    initial
    begin
        repeat (20) @(negedge clk_i);
        check(p1_oe_n_o, 8'hFF);
        check(p1_out_o, 8'hFF);
        check(8'(status_o), 8'h00);
        chk1(tx_ready_o, 1'b1);
        resetn_i = 1'b1;
        cfg.spi_enable_bit = 1'b1;
        cfg.irq_enable = 1'b1;
        master_set_i = 1'b1;
        tick(1);
        master_set_i = 1'b0;
        tick(2);
        chk1(status_o.master_select_bit, 1'b1);
        mxfer(8'hA5, 8'h3C, 3'h0, 2);
        cfg.bit_order_control = 1'b1;
        cfg.remap = 1'b1;
        // let the moved clock pin settle before the model's counters restart
        tick(3);
        mxfer(8'h81, 8'h4E, 3'h2, 8);
        // quasi-bidirectional pins for the timer-paced byte
        port_mode_i = 16'h0000;
        mxfer(8'h5A, 8'hC3, 3'h7, 10);
        cfg.bit_order_control = 1'b0;
        cfg.remap = 1'b0;
        // input-only pins stay undriven through the first 40 cycles of a transfer
        port_mode_i = 16'hAAAA;
        send(8'h77);
        for (int n = 0; n < 40; n++)
        begin
            tick(1);
            check(p1_oe_n_o, 8'hFF);
        end
        wait_transfer_complete_flag();
        clr_transfer_complete_flag();
        port_mode_i = 16'h5555;
        // select pin as general output, low level causes no fault
        cfg.select_disable_bit = 1'b1;
        ss_gpio_i = 1'b0;
        tick(5);
        chk1(p1_oe_n_o[u_far.ss_p], 1'b0);
        chk1(p1_out_o[u_far.ss_p], 1'b0);
        chk1(status_o.master_select_bit, 1'b1);
        chk1(status_o.mode_fault_flag, 1'b0);
        // raise the driven select level before checking resumes, so no fault is made
        ss_gpio_i = 1'b1;
        tick(2);
        cfg.select_disable_bit = 1'b0;
        tick(2);
        chk1(status_o.mode_fault_flag, 1'b0);
        // select pulled low in mid-transfer
        send(8'hFF);
        tick(6);
        u_far.ss_drv = 1'b1;
        u_far.ss_v = 1'b0;
        tick(3);
        chk1(status_o.master_select_bit, 1'b0);
        chk1(p1_oe_n_o[u_far.sck_p], 1'b1);
        chk1(p1_oe_n_o[u_far.mosi_p], 1'b1);
        chk1(status_o.mode_fault_flag, 1'b1);
        chk1(irq_o, 1'b1);
        u_far.ss_drv = 1'b0;
        tick(10);
        chk1(status_o.master_select_bit, 1'b0);
        cfg.select_disable_bit = 1'b1;
        tick(2);
        cfg.select_disable_bit = 1'b0;
        tick(2);
        chk1(status_o.mode_fault_flag, 1'b1);
        mode_fault_flag_clr_i = 1'b1;
        tick(1);
        mode_fault_flag_clr_i = 1'b0;
        tick(2);
        chk1(status_o.mode_fault_flag, 1'b0);
        chk1(irq_o, 1'b0);
        // slave role with the model as master
        u_far.mst_on = 1'b1;
        tick(4);
        chk1(p1_oe_n_o[u_far.miso_p], 1'b1);
        fork
            sframe(8'h96, 8'h2D, 1'b0, 1'b1);
            begin
                tick(16);
                chk1(p1_oe_n_o[u_far.miso_p], 1'b0);
            end
        join
        chk1(p1_oe_n_o[u_far.miso_p], 1'b1);
        cfg.cpha = 1'b1;
        cfg.select_disable_bit = 1'b1;
        sframe(8'hE1, 8'h1E, 1'b1, 1'b0);
        cfg.cpha = 1'b0;
        cfg.select_disable_bit = 1'b0;
        isp_active_i = 1'b1;
        sframe(8'h69, 8'hB4, 1'b0, 1'b1);
        isp_active_i = 1'b0;
        // select rises after three bits
        u_far.frame(8'hC0, 1'b0, 1'b1, 3);
        tick(4);
        chk1(status_o.select_error_flag, 1'b1);
        chk1(irq_o, 1'b0);
        cfg.spi_enable_bit = 1'b0;
        tick(3);
        chk1(status_o.select_error_flag, 1'b0);
        wrap_up();
    end

    // watchdog well beyond the expected run
    initial
    begin
        repeat (30000) @(posedge clk_i);
        n_mismatch++;
        wrap_up();
    end
endmodule
